// File: logic/irqrm_pkg.sv
package irqrm_pkg;

    // ------------------------------------------------------------------
    // Register file geometry
    // ------------------------------------------------------------------
    localparam int IRQRM_NUM_GROUPS = 5;
    localparam int IRQRM_NUM_REGS = 10;
    localparam int IRQRM_FLAG_BITS = 40;
    localparam int IRQRM_MASK_BASE = 5;

    // Byte addresses, index 0..4 pending flags, 5..9 mask flags
    localparam logic [19:0] IRQRM_ADDR_PEND_G0_LOW = 20'hfffe0;
    localparam logic [19:0] IRQRM_ADDR_PEND_G0_HIGH = 20'hfffe1;
    localparam logic [19:0] IRQRM_ADDR_PEND_G1_LOW = 20'hfffe2;
    localparam logic [19:0] IRQRM_ADDR_PEND_G1_HIGH = 20'hfffe3;
    localparam logic [19:0] IRQRM_ADDR_PEND_G2_HIGH = 20'hfffd1;
    localparam logic [19:0] IRQRM_ADDR_MASK_G0_LOW = 20'hfffe4;
    localparam logic [19:0] IRQRM_ADDR_MASK_G0_HIGH = 20'hfffe5;
    localparam logic [19:0] IRQRM_ADDR_MASK_G1_LOW = 20'hfffe6;
    localparam logic [19:0] IRQRM_ADDR_MASK_G1_HIGH = 20'hfffe7;
    localparam logic [19:0] IRQRM_ADDR_MASK_G2_HIGH = 20'hfffd5;

    localparam logic [19:0] IRQRM_REG_ADDR [IRQRM_NUM_REGS] = '{
        IRQRM_ADDR_PEND_G0_LOW, IRQRM_ADDR_PEND_G0_HIGH, IRQRM_ADDR_PEND_G1_LOW,
        IRQRM_ADDR_PEND_G1_HIGH, IRQRM_ADDR_PEND_G2_HIGH, IRQRM_ADDR_MASK_G0_LOW,
        IRQRM_ADDR_MASK_G0_HIGH, IRQRM_ADDR_MASK_G1_LOW, IRQRM_ADDR_MASK_G1_HIGH,
        IRQRM_ADDR_MASK_G2_HIGH
    };

    // Implemented bit positions of each group
    localparam logic [7:0] IRQRM_VALID_G0_LOW = 8'hff;
    localparam logic [7:0] IRQRM_VALID_G0_HIGH = 8'he0;
    localparam logic [7:0] IRQRM_VALID_G1_LOW = 8'hf7;
    localparam logic [7:0] IRQRM_VALID_G1_HIGH = 8'h45;
    localparam logic [7:0] IRQRM_VALID_G2_HIGH = 8'h86;
    localparam logic [7:0] IRQRM_REG_VALID [IRQRM_NUM_REGS] = '{
        IRQRM_VALID_G0_LOW, IRQRM_VALID_G0_HIGH, IRQRM_VALID_G1_LOW,
        IRQRM_VALID_G1_HIGH, IRQRM_VALID_G2_HIGH,
        IRQRM_VALID_G0_LOW, IRQRM_VALID_G0_HIGH, IRQRM_VALID_G1_LOW,
        IRQRM_VALID_G1_HIGH, IRQRM_VALID_G2_HIGH
    };

    // Reset values and the fixed level of unassigned positions
    localparam logic [7:0] IRQRM_PEND_RESET = 8'h00;
    localparam logic [7:0] IRQRM_MASK_RESET = 8'hff;
    localparam logic [7:0] IRQRM_PEND_FIXED = 8'h00;
    localparam logic [7:0] IRQRM_MASK_FIXED = 8'hff;

    // Word pairs start at these even addresses
    localparam logic [19:0] IRQRM_WORD_PEND_G0 = IRQRM_ADDR_PEND_G0_LOW;
    localparam logic [19:0] IRQRM_WORD_PEND_G1 = IRQRM_ADDR_PEND_G1_LOW;
    localparam logic [19:0] IRQRM_WORD_MASK_G0 = IRQRM_ADDR_MASK_G0_LOW;
    localparam logic [19:0] IRQRM_WORD_MASK_G1 = IRQRM_ADDR_MASK_G1_LOW;

    // Shared flag positions in the flat 40-bit flag space (group*8+bit)
    localparam int IRQRM_SHARED_SERIAL0_POS = 13;
    localparam int IRQRM_SHARED_RXERR0_POS = 15;
    localparam int IRQRM_SHARED_RXERR1_POS = 18;

    // Extra execution clocks added to every write
    localparam logic [1:0] IRQRM_WRITE_EXTRA_CLOCKS = 2'h2;

    // Access width of a CPU memory instruction
    typedef enum logic [1:0] {
        IRQRM_ACC_BIT,
        IRQRM_ACC_BYTE,
        IRQRM_ACC_WORD,
        IRQRM_ACC_NONE
    } irqrm_access_e;

endpackage : irqrm_pkg

// File: logic/irqrm_flag_byte.sv
`timescale 1ns/1ns
`default_nettype none

module irqrm_flag_byte
    import irqrm_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] VALID = 8'hff,
    parameter logic [7:0] FIXED = 8'h00
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Write lanes from the CPU
    input wire logic [7:0] wr_bits,
    input wire logic [7:0] wr_val,
    // Hardware set and clear
    input wire logic [7:0] set_bits,
    input wire logic [7:0] clr_bits,
    // Current value
    output logic [7:0] q
);

    typedef struct packed {
        logic [7:0] flags;
    } irqrm_byte_s;

    irqrm_byte_s st;
    irqrm_byte_s next_st;

    // Write first, then acknowledge clear, then source set: an event never gets lost
    always_comb begin
        next_st = st;
        next_st.flags = (st.flags & ~wr_bits) | (wr_val & wr_bits);
        next_st.flags = next_st.flags & ~clr_bits;
        next_st.flags = next_st.flags | set_bits;
        next_st.flags = (next_st.flags & VALID) | (FIXED & ~VALID);
    end

    // Register the state
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st.flags <= (RESET_VAL & VALID) | (FIXED & ~VALID);
        end else begin
            st <= next_st;
        end
    end

    assign q = st.flags;

endmodule : irqrm_flag_byte

`default_nettype wire

// File: logic/irqrm_write_stretch.sv
`timescale 1ns/1ns
`default_nettype none

module irqrm_write_stretch
    import irqrm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Accepted write
    input wire logic start,
    // Wait towards the CPU
    output logic busy
);

    typedef struct packed {
        logic [1:0] count;
    } irqrm_stretch_s;

    irqrm_stretch_s st;
    irqrm_stretch_s next_st;

    // Load on an accepted write, count down to idle
    always_comb begin
        next_st = st;
        if (start) begin
            next_st.count = IRQRM_WRITE_EXTRA_CLOCKS;
        end else if (st.count != 2'h0) begin
            next_st.count = st.count - 2'h1;
        end
    end

    // Register the state
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st.count <= 2'h0;
        end else begin
            st <= next_st;
        end
    end

    assign busy = (st.count != 2'h0);

endmodule : irqrm_write_stretch

`default_nettype wire

// File: logic/irqrm_top.sv
// What this block does
// - Any of three serial sources sets shared flag at group0-high bit 5.
// - Mask bit 5 of group0-high gates all three serial sources together.
// - Receive-error 0 or timer 1 upper half sets group0-high bit 7.
// - Mask bit 7 of group0-high is one control for both those sources.
// - Receive-error 1 or timer 3 upper half sets group1-low bit 2.
// - Mask bit 2 of group1-low is one control for both those sources.
// - A flag sets on its source request or on a CPU write of 1.
// - Acknowledge clears the flag before service entry; writing 0 clears too.
// - Reset clears all five pending registers to zero.
// - Single-bit and byte writes reach every pending and mask register.
// - Low/high pairs of groups 0 and 1 also take 16-bit access.
// - Each write stalls the CPU for two extra clocks.
// - Pending flag reads 1 while a request is pending, else 0.
// - Mask 0 allows servicing, mask 1 blocks it.
// - Reset sets all five mask registers to all ones.
// - A byte write replaces every implemented flag of the register; unassigned positions keep their fixed level.
`timescale 1ns/1ns
`default_nettype none

module irqrm_top
    import irqrm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // CPU memory access
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [1:0] bus_access,
    input wire logic [19:0] bus_addr,
    input wire logic [2:0] bus_bit_pos,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic bus_rvalid,
    output logic bus_wait,
    // Peripheral requests, one pulse per event, flat group*8+bit
    input wire logic [39:0] periph_request,
    // Shared sources
    input wire logic serial0_transmit_request,
    input wire logic clocked_serial_request,
    input wire logic two_wire_serial_request,
    input wire logic serial0_receive_error_request,
    input wire logic timer_ch1_upper_request,
    input wire logic serial1_receive_error_request,
    input wire logic timer_ch3_upper_request,
    // Acknowledge from the arbiter
    input wire logic ack_valid,
    input wire logic [5:0] ack_flag_index,
    // Flag state towards the arbiter
    output logic [39:0] pending_flags,
    output logic [39:0] mask_flags,
    output logic [39:0] service_request
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] rdata;
        logic rvalid;
    } irqrm_top_s;

    irqrm_top_s st;
    irqrm_top_s next_st;

    logic [7:0] reg_q [IRQRM_NUM_REGS];
    logic [7:0] reg_wbits [IRQRM_NUM_REGS];
    logic [7:0] reg_wval [IRQRM_NUM_REGS];
    logic [7:0] reg_set [IRQRM_NUM_REGS];
    logic [7:0] reg_clr [IRQRM_NUM_REGS];
    logic [39:0] event_flat;
    logic stretch_busy;
    logic wr_go;
    logic word_ok;

    // ------------------------------------------------------------------
    // Request gathering
    // ------------------------------------------------------------------
    // Shared positions cannot tell the sources apart; software must keep one enabled
    always_comb begin
        event_flat = periph_request;
        event_flat[IRQRM_SHARED_SERIAL0_POS] = periph_request[IRQRM_SHARED_SERIAL0_POS]
            | serial0_transmit_request | clocked_serial_request
            | two_wire_serial_request;
        event_flat[IRQRM_SHARED_RXERR0_POS] = periph_request[IRQRM_SHARED_RXERR0_POS]
            | serial0_receive_error_request | timer_ch1_upper_request;
        event_flat[IRQRM_SHARED_RXERR1_POS] = periph_request[IRQRM_SHARED_RXERR1_POS]
            | serial1_receive_error_request | timer_ch3_upper_request;
    end

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    // Writes during the stretch are dropped; the CPU is held by bus_wait anyway
    assign wr_go = bus_wr && !stretch_busy;

    // Word access only at the even start of a pairable group
    assign word_ok = (bus_addr == IRQRM_WORD_PEND_G0) || (bus_addr == IRQRM_WORD_PEND_G1)
        || (bus_addr == IRQRM_WORD_MASK_G0) || (bus_addr == IRQRM_WORD_MASK_G1);

    // Lane mask and value per register
    always_comb begin
        for (int r = 0; r < IRQRM_NUM_REGS; r++) begin
            reg_wbits[r] = 8'h00;
            reg_wval[r] = 8'h00;
            if (wr_go) begin
                case (bus_access)
                    IRQRM_ACC_BIT: begin
                        if (bus_addr == IRQRM_REG_ADDR[r]) begin
                            reg_wbits[r] = 8'h01 << bus_bit_pos;
                            reg_wval[r] = {8{bus_wdata[0]}};
                        end
                    end
                    IRQRM_ACC_BYTE: begin
                        if (bus_addr == IRQRM_REG_ADDR[r]) begin
                            reg_wbits[r] = 8'hff;
                            reg_wval[r] = bus_wdata[7:0];
                        end
                    end
                    IRQRM_ACC_WORD: begin
                        if (word_ok && bus_addr == IRQRM_REG_ADDR[r]) begin
                            reg_wbits[r] = 8'hff;
                            reg_wval[r] = bus_wdata[7:0];
                        end else if (word_ok && (bus_addr + 20'h1) == IRQRM_REG_ADDR[r]) begin
                            reg_wbits[r] = 8'hff;
                            reg_wval[r] = bus_wdata[15:8];
                        end
                    end
                    default: begin
                        reg_wbits[r] = 8'h00;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Set and clear per register
    // ------------------------------------------------------------------
    // Only pending registers see events and acknowledges
    always_comb begin
        for (int r = 0; r < IRQRM_NUM_REGS; r++) begin
            reg_set[r] = 8'h00;
            reg_clr[r] = 8'h00;
            if (r < IRQRM_MASK_BASE) begin
                reg_set[r] = event_flat[r*8 +: 8];
                if (ack_valid && ack_flag_index[5:3] == r[2:0]) begin
                    reg_clr[r] = 8'h01 << ack_flag_index[2:0];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Flag registers
    // ------------------------------------------------------------------
    for (genvar g = 0; g < IRQRM_NUM_REGS; g++) begin : gen_reg
        irqrm_flag_byte #(
            .RESET_VAL((g < IRQRM_MASK_BASE) ? IRQRM_PEND_RESET : IRQRM_MASK_RESET),
            .VALID(IRQRM_REG_VALID[g]),
            .FIXED((g < IRQRM_MASK_BASE) ? IRQRM_PEND_FIXED : IRQRM_MASK_FIXED)
        ) u_byte (
            .core_clk(core_clk),
            .reset_n(reset_n),
            .wr_bits(reg_wbits[g]),
            .wr_val(reg_wval[g]),
            .set_bits(reg_set[g]),
            .clr_bits(reg_clr[g]),
            .q(reg_q[g])
        );
    end

    // Write stretch towards the CPU
    irqrm_write_stretch u_stretch (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .start(wr_go),
        .busy(stretch_busy)
    );

    assign bus_wait = stretch_busy;

    // ------------------------------------------------------------------
    // Flag outputs
    // ------------------------------------------------------------------
    // One mask bit covers every source folded into a shared flag
    always_comb begin
        for (int r = 0; r < IRQRM_NUM_GROUPS; r++) begin
            pending_flags[r*8 +: 8] = reg_q[r];
            mask_flags[r*8 +: 8] = reg_q[r + IRQRM_MASK_BASE];
        end
    end

    assign service_request = pending_flags & ~mask_flags;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Registered read data, one cycle after the request; unmapped reads give zero
    always_comb begin
        next_st = st;
        next_st.rvalid = bus_rd;
        next_st.rdata = 16'h0000;
        if (bus_rd) begin
            for (int r = 0; r < IRQRM_NUM_REGS; r++) begin
                case (bus_access)
                    IRQRM_ACC_BIT: begin
                        if (bus_addr == IRQRM_REG_ADDR[r]) begin
                            next_st.rdata = {15'h0000, reg_q[r][bus_bit_pos]};
                        end
                    end
                    IRQRM_ACC_BYTE: begin
                        if (bus_addr == IRQRM_REG_ADDR[r]) begin
                            next_st.rdata = {8'h00, reg_q[r]};
                        end
                    end
                    IRQRM_ACC_WORD: begin
                        if (word_ok && bus_addr == IRQRM_REG_ADDR[r]) begin
                            next_st.rdata = {reg_q[(r + 1) % IRQRM_NUM_REGS], reg_q[r]};
                        end
                    end
                    default: begin
                        next_st.rdata = next_st.rdata;
                    end
                endcase
            end
        end
    end

    // Register the state
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st.rdata <= 16'h0000;
            st.rvalid <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign bus_rdata = st.rdata;
    assign bus_rvalid = st.rvalid;

endmodule : irqrm_top

`default_nettype wire

// File: tb/irqrm_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------------
// Port checks for the request and mask flags
// ------------------------------------------------------------------
module irqrm_checker
    import irqrm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // CPU side
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_rvalid,
    input wire logic bus_wait,
    // Sources and acknowledge
    input wire logic [39:0] periph_request,
    input wire logic serial0_transmit_request,
    input wire logic clocked_serial_request,
    input wire logic two_wire_serial_request,
    input wire logic serial0_receive_error_request,
    input wire logic timer_ch1_upper_request,
    input wire logic serial1_receive_error_request,
    input wire logic timer_ch3_upper_request,
    input wire logic ack_valid,
    input wire logic [5:0] ack_flag_index,
    // Flag state
    input wire logic [39:0] pending_flags,
    input wire logic [39:0] mask_flags,
    input wire logic [39:0] service_request
);
    localparam logic [39:0] FLAT_VALID = {IRQRM_VALID_G2_HIGH, IRQRM_VALID_G1_HIGH,
        IRQRM_VALID_G1_LOW, IRQRM_VALID_G0_HIGH, IRQRM_VALID_G0_LOW};
    logic calm;
    // No accepted write and no source event; ack is left out on purpose
    assign calm = !(bus_wr && !bus_wait) && periph_request == 40'h0 &&
        !(serial0_transmit_request || clocked_serial_request || two_wire_serial_request ||
        serial0_receive_error_request || timer_ch1_upper_request ||
        serial1_receive_error_request || timer_ch3_upper_request);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Stall of a write: two cycles high, then free again
    sequence wait_two;
        bus_wait [*2] ##1 !bus_wait;
    endsequence
    write_wait_a: assert property (bus_wr && !bus_wait |=> wait_two)
        else $error("bus_wait did not stand two cycles");
    read_answer_a: assert property (bus_rd |=> bus_rvalid)
        else $error("read got no answer");
    serial_share_a: assert property (serial0_transmit_request || clocked_serial_request ||
        two_wire_serial_request |=> pending_flags[13])
        else $error("serial flag not set");
    rxerr0_share_a: assert property (serial0_receive_error_request ||
        timer_ch1_upper_request |=> pending_flags[15])
        else $error("receive error 0 flag not set");
    rxerr1_share_a: assert property (serial1_receive_error_request ||
        timer_ch3_upper_request |=> pending_flags[18])
        else $error("receive error 1 flag not set");
    event_set_a: assert property (periph_request != 40'h0 |=> (pending_flags &
        $past(periph_request) & FLAT_VALID) == ($past(periph_request) & FLAT_VALID))
        else $error("event flag not set");
    ack_clear_a: assert property (ack_valid && ack_flag_index < 6'd40 && calm
        |=> !pending_flags[$past(ack_flag_index)])
        else $error("acknowledged flag not cleared");
    service_gate_a: assert property (service_request == (pending_flags & ~mask_flags))
        else $error("service request not gated by mask");
    fixed_bits_a: assert property ((pending_flags & ~FLAT_VALID) == 40'h0 &&
        (mask_flags | FLAT_VALID) == {40{1'b1}})
        else $error("unassigned flag position moved");
    flags_hold_a: assert property (calm && !ack_valid
        |=> $stable(pending_flags) && $stable(mask_flags))
        else $error("flags changed without cause");
endmodule : irqrm_checker
`default_nettype wire

// File: tb/irqrm_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------------
// CPU core issuing memory instructions
// ------------------------------------------------------------------
module irqrm_cpu_model
    import irqrm_pkg::*;
(
    // Clock and stall
    input wire logic core_clk,
    input wire logic bus_wait,
    // Requests
    output logic bus_wr,
    output logic bus_rd,
    output logic [1:0] bus_access,
    output logic [19:0] bus_addr,
    output logic [2:0] bus_bit_pos,
    output logic [15:0] bus_wdata
);
    // Released bus flips address, bit position and data so a stale value never looks valid
    task automatic idle();
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_access = IRQRM_ACC_NONE;
        bus_addr = ~bus_addr;
        bus_bit_pos = ~bus_bit_pos;
        bus_wdata = ~bus_wdata;
    endtask : idle
    initial begin
        bus_addr = 20'h0;
        bus_bit_pos = 3'h0;
        bus_wdata = 16'h0;
        idle();
    end
    // Pending positions without a source are written 0 by byte and word writes
    function automatic logic [15:0] clean(logic [1:0] acc, logic [19:0] a, logic [15:0] d);
        logic [15:0] r;
        r = d;
        for (int i = 0; i < IRQRM_MASK_BASE; i++) begin
            if (acc != IRQRM_ACC_BIT && a == IRQRM_REG_ADDR[i]) begin
                r[7:0] &= IRQRM_REG_VALID[i];
            end
            if (acc == IRQRM_ACC_WORD && a + 20'h1 == IRQRM_REG_ADDR[i]) begin
                r[15:8] &= IRQRM_REG_VALID[i];
            end
        end
        return r;
    endfunction : clean
    // Write; unspaced only when a refusal is wanted
    task automatic wr(logic [1:0] acc, logic [19:0] a, logic [2:0] p, logic [15:0] d, bit spaced);
        bus_access = acc;
        bus_addr = a;
        bus_bit_pos = p;
        bus_wdata = clean(acc, a, d);
        bus_wr = 1'b1;
        @(posedge core_clk);
        #1;
        idle();
        // An edge always passes after release; a spaced write waits out the stall
        repeat (spaced ? 2 : 1) @(posedge core_clk);
        #1;
    endtask : wr
    // Read; the answer is watched by the bench
    task automatic rd(logic [1:0] acc, logic [19:0] a, logic [2:0] p);
        bus_access = acc;
        bus_addr = a;
        bus_bit_pos = p;
        bus_rd = 1'b1;
        @(posedge core_clk);
        #1;
        idle();
        @(posedge core_clk); // Gap keeps the strobe from being rewritten in one step
        #1;
    endtask : rd
endmodule : irqrm_cpu_model
`default_nettype wire

// File: tb/tb_irq_request_mask_flags.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------------
// Bench: CPU model, source pulses and a read scoreboard
// ------------------------------------------------------------------
module tb_irq_request_mask_flags
    import irqrm_pkg::*;
;
    typedef struct packed {logic [15:0] m; logic [15:0] v;} irqrm_note_s;
    irqrm_note_s notes[$];
    irqrm_note_s note;
    logic core_clk, reset_n, bus_wr, bus_rd, bus_rvalid, bus_wait, ack_valid;
    logic [1:0] bus_access;
    logic [19:0] bus_addr;
    logic [2:0] bus_bit_pos, p;
    logic [15:0] bus_wdata, bus_rdata, w;
    logic [39:0] periph_request, pending_flags, mask_flags, service_request;
    logic [6:0] src_req;
    logic [5:0] ack_flag_index;
    logic [7:0] d;
    int fail_count = 0;
    int n_checks = 0;
    int j;
    int lo_idx[4] = '{0, 2, 5, 7};
    int spos[7] = '{13, 13, 13, 15, 15, 18, 18};
    irqrm_cpu_model cpu_u (.core_clk, .bus_wait, .bus_wr, .bus_rd, .bus_access, .bus_addr,
        .bus_bit_pos, .bus_wdata);
    irqrm_top dut_u (.core_clk, .reset_n, .bus_wr, .bus_rd, .bus_access, .bus_addr,
        .bus_bit_pos, .bus_wdata, .bus_rdata, .bus_rvalid, .bus_wait, .periph_request,
        .serial0_transmit_request(src_req[0]), .clocked_serial_request(src_req[1]),
        .two_wire_serial_request(src_req[2]), .serial0_receive_error_request(src_req[3]),
        .timer_ch1_upper_request(src_req[4]), .serial1_receive_error_request(src_req[5]),
        .timer_ch3_upper_request(src_req[6]), .ack_valid, .ack_flag_index, .pending_flags,
        .mask_flags, .service_request);
    // Clock, 100 ns period
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic tally_and_finish();
        if (fail_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    // Whole run needs about 390 cycles; give it 5000
    initial begin
        #500000;
        fail_count++;
        tally_and_finish();
    end
    // Read answers are settled at the falling edge
    always @(negedge core_clk) begin
        if (bus_rvalid === 1'b1) begin
            note = notes.pop_front();
            n_checks++;
            if ((bus_rdata & note.m) !== note.v) begin
                fail_count++;
                $display("Error bus_rdata expected %h seen %h", note.v, bus_rdata & note.m);
            end
        end
    end
    function automatic logic [7:0] exp_val(int i, logic [7:0] x);
        return (i < 5) ? (x & IRQRM_REG_VALID[i]) : (x | ~IRQRM_REG_VALID[i]);
    endfunction : exp_val
    task automatic chk(logic [1:0] acc, logic [19:0] a, logic [2:0] q, logic [15:0] e);
        notes.push_back({(acc == IRQRM_ACC_BIT) ? 16'h0001 :
            (acc == IRQRM_ACC_BYTE) ? 16'h00ff : 16'hffff, e});
        cpu_u.rd(acc, a, q);
    endtask : chk
    task automatic pulse(logic [39:0] pr, logic [6:0] s, logic av, int ai);
        periph_request = pr;
        src_req = s;
        ack_valid = av;
        ack_flag_index = 6'(ai);
        @(posedge core_clk);
        #1;
        periph_request = 40'h0;
        src_req = 7'h0;
        ack_valid = 1'b0;
    endtask : pulse
    task automatic do_reset();
        reset_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        for (int i = 0; i < IRQRM_NUM_REGS; i++) begin
            d = (i < IRQRM_MASK_BASE) ? IRQRM_PEND_RESET : IRQRM_MASK_RESET;
            chk(IRQRM_ACC_BYTE, IRQRM_REG_ADDR[i], 3'h0, {8'h00, exp_val(i, d)});
        end
    endtask : do_reset
    // Main sequence
    initial begin
        periph_request = 40'h0;
        src_req = 7'h0;
        ack_valid = 1'b0;
        ack_flag_index = 6'h0;
        void'($urandom(32'h8ecb751a));
        do_reset();
        for (int i = 0; i < IRQRM_NUM_REGS; i++) begin
            d = 8'($urandom);
            cpu_u.wr(IRQRM_ACC_BYTE, IRQRM_REG_ADDR[i], 3'h0, {8'h00, d}, 1'b1);
            chk(IRQRM_ACC_BYTE, IRQRM_REG_ADDR[i], 3'h0, {8'h00, exp_val(i, d)});
            do p = 3'($urandom); while (!IRQRM_REG_VALID[i][p]);
            cpu_u.wr(IRQRM_ACC_BIT, IRQRM_REG_ADDR[i], p, 16'h1, 1'b1);
            chk(IRQRM_ACC_BIT, IRQRM_REG_ADDR[i], p, 16'h1);
            cpu_u.wr(IRQRM_ACC_BIT, IRQRM_REG_ADDR[i], p, 16'h0, 1'b1);
            chk(IRQRM_ACC_BIT, IRQRM_REG_ADDR[i], p, 16'h0);
        end
        foreach (lo_idx[k]) begin
            w = 16'($urandom);
            cpu_u.wr(IRQRM_ACC_WORD, IRQRM_REG_ADDR[lo_idx[k]], 3'h0, w, 1'b1);
            chk(IRQRM_ACC_WORD, IRQRM_REG_ADDR[lo_idx[k]], 3'h0,
                {exp_val(lo_idx[k] + 1, w[15:8]), exp_val(lo_idx[k], w[7:0])});
            chk(IRQRM_ACC_BYTE, IRQRM_REG_ADDR[lo_idx[k] + 1], 3'h0,
                {8'h00, exp_val(lo_idx[k] + 1, w[15:8])});
        end
        chk(IRQRM_ACC_BYTE, 20'hfffe8, 3'h0, 16'h0);
        chk(IRQRM_ACC_WORD, IRQRM_ADDR_PEND_G0_HIGH, 3'h0, 16'h0);
        foreach (spos[s]) begin
            cpu_u.wr(IRQRM_ACC_BIT, IRQRM_REG_ADDR[spos[s] / 8], 3'(spos[s] % 8),
                16'h0, 1'b1);
            pulse(40'h0, 7'(1 << s), 1'b0, 0);
            chk(IRQRM_ACC_BIT, IRQRM_REG_ADDR[spos[s] / 8], 3'(spos[s] % 8), 16'h1);
        end
        repeat (6) begin
            do j = $urandom_range(39); while (!IRQRM_REG_VALID[j / 8][j % 8]);
            cpu_u.wr(IRQRM_ACC_BIT, IRQRM_REG_ADDR[j / 8], 3'(j % 8), 16'h0, 1'b1);
            pulse(40'h1 << j, 7'h0, 1'b0, 0);
            chk(IRQRM_ACC_BIT, IRQRM_REG_ADDR[j / 8], 3'(j % 8), 16'h1);
            pulse(40'h0, 7'h0, 1'b1, j);
            chk(IRQRM_ACC_BIT, IRQRM_REG_ADDR[j / 8], 3'(j % 8), 16'h0);
            pulse(40'h1 << j, 7'h0, 1'b1, j);
            chk(IRQRM_ACC_BIT, IRQRM_REG_ADDR[j / 8], 3'(j % 8), 16'h1);
            cpu_u.wr(IRQRM_ACC_BYTE, IRQRM_REG_ADDR[j / 8], 3'h0, 16'h0, 1'b1);
            chk(IRQRM_ACC_BIT, IRQRM_REG_ADDR[j / 8], 3'(j % 8), 16'h0);
        end
        cpu_u.wr(IRQRM_ACC_BYTE, IRQRM_ADDR_MASK_G2_HIGH, 3'h0, 16'h0, 1'b0);
        cpu_u.wr(IRQRM_ACC_BYTE, IRQRM_ADDR_MASK_G2_HIGH, 3'h0, 16'hff, 1'b1);
        chk(IRQRM_ACC_BYTE, IRQRM_ADDR_MASK_G2_HIGH, 3'h0, {8'h00, exp_val(9, 8'h00)});
        do_reset();
        repeat (4) @(posedge core_clk);
        tally_and_finish();
    end
endmodule : tb_irq_request_mask_flags
bind irqrm_top irqrm_checker chk_u (.core_clk, .reset_n, .bus_wr, .bus_rd, .bus_rvalid,
    .bus_wait, .periph_request, .serial0_transmit_request, .clocked_serial_request,
    .two_wire_serial_request, .serial0_receive_error_request, .timer_ch1_upper_request,
    .serial1_receive_error_request, .timer_ch3_upper_request, .ack_valid, .ack_flag_index,
    .pending_flags, .mask_flags, .service_request);
`default_nettype wire
